// file: rtl/ssf_pkg.sv
// package: register map, field layout and carrier types for the serial status flag logic
package ssf_pkg;
    // byte addresses on the register bus
    localparam logic [4:0] SSF_OFS_CTRL = 5'h00;
    localparam logic [4:0] SSF_OFS_STATUS = 5'h04;
    localparam logic [4:0] SSF_OFS_DATA_HIGH = 5'h08;
    localparam logic [4:0] SSF_OFS_DATA_LOW = 5'h0C;
    // status_flags_one bit positions
    localparam int SSF_BIT_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int SSF_BIT_TC = 6;
    localparam int SSF_BIT_RX_FULL_FLAG = 5;
    localparam int SSF_BIT_IDLE = 4;
    localparam int SSF_BIT_OVR = 3;
    localparam int SSF_BIT_NF = 2;
    localparam int SSF_BIT_FE = 1;
    localparam int SSF_BIT_PF = 0;
    // control register bit positions
    localparam int SSF_CTL_NINE = 0;
    localparam int SSF_CTL_PAR_EN = 1;
    localparam int SSF_CTL_PAR_ODD = 2;
    localparam int SSF_CTL_WAKEUP = 3;
    localparam int SSF_CTL_RIE = 4;
    // data_high positions: received ninth bit reads, transmit ninth bit writes
    localparam int SSF_DH_R8 = 7;
    localparam int SSF_DH_T8 = 6;
    // values after reset
    localparam logic [7:0] SSF_FLAGS_RST = 8'hC0;
    localparam logic [4:0] SSF_CTRL_RST = 5'h00;
    // idle line lengths in bit times
    localparam logic [3:0] SSF_IDLE_BITS_8 = 4'hA;
    localparam logic [3:0] SSF_IDLE_BITS_9 = 4'hB;

    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tc;
        logic rx_full_flag;
        logic idle;
        logic ovr;
        logic nf;
        logic fe;
        logic pf;
    } ssf_flags_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } ssf_avl_req_t;

    typedef struct packed {
        logic load;
        logic busy;
        logic queue;
        logic line_bit;
    } ssf_tx_evt_t;

    typedef struct packed {
        logic valid;
        logic [8:0] data;
        logic parity_bit;
        logic noise;
        logic stop_low;
    } ssf_rx_evt_t;
endpackage

// file: rtl/ssf_idle_detect.sv
// idle line detector: pulses once per run of at least 10 consecutive high bit times, or 11 with nine_bits
`timescale 1ns/1ns
`default_nettype none
module ssf_idle_detect
    import ssf_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // line and timing
    input wire logic rx_level,
    input wire logic bit_tick,
    input wire logic nine_bits,
    // result
    output logic idle_pulse
);
    typedef struct packed {
        logic [3:0] count;
        logic fired;
        logic pulse;
    } ssf_idle_state_t;

    ssf_idle_state_t s_q;
    ssf_idle_state_t s_d;
    logic [3:0] target;

    always_comb
    begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        target = nine_bits ? SSF_IDLE_BITS_9 : SSF_IDLE_BITS_8;
        if (bit_tick)
        begin
            if (!rx_level)
            begin
                s_d.count = 4'h0;
                s_d.fired = 1'b0;
            end
            else if (!s_q.fired)
            begin
                s_d.count = s_q.count + 4'h1;
                // one pulse per run, so a long idle line cannot retrigger
                if (s_d.count >= target)
                begin
                    s_d.pulse = 1'b1;
                    s_d.fired = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign idle_pulse = s_q.pulse;
endmodule
`default_nettype wire

// file: rtl/ssf_status_flags.sv
// serial status flag logic with its register bus slave
`timescale 1ns/1ns
`default_nettype none
module ssf_status_flags
    import ssf_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register bus
    input wire ssf_pkg::ssf_avl_req_t avl_req,
    output logic avl_waitrequest,
    output logic [31:0] avl_readdata,
    // transmit engine
    input wire ssf_pkg::ssf_tx_evt_t tx_evt,
    output logic [8:0] tx_word,
    output logic tx_word_pending,
    output logic tx_pin,
    // receive engine and line
    input wire ssf_pkg::ssf_rx_evt_t rx_evt,
    input wire logic rx_pin,
    input wire logic rx_bit_tick,
    output logic rx_hold,
    output logic frame_nine_bits,
    output logic parity_enable,
    output logic parity_kind,
    output logic rx_wakeup_standby,
    // interrupt request
    output logic rx_irq_req
);
    import ssf_pkg::*;

    typedef struct packed {
        ssf_flags_t flags;
        ssf_flags_t armed;
        logic idle_allow;
        logic busy_seen;
        logic [4:0] ctrl;
        logic [8:0] tx_word;
        logic [8:0] rx_word;
        logic rx_meta;
        logic rx_sync;
        logic waitreq;
        logic [31:0] rdata;
        logic tx_pin;
        logic tx_pending;
        logic rx_hold;
        logic irq;
    } ssf_state_t;

    ssf_state_t s_q;
    ssf_state_t s_d;
    logic idle_pulse;
    logic bus_go;
    logic st_rd;
    logic dl_rd;
    logic dl_wr;
    logic dh_wr;
    logic ctl_wr;
    logic accept;
    logic par_bad;
    logic tc_sw_clear;

    ssf_idle_detect u_idle
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .rx_level(s_q.rx_sync),
        .bit_tick(rx_bit_tick),
        .nine_bits(s_q.ctrl[SSF_CTL_NINE]),
        .idle_pulse(idle_pulse)
    );

    always_comb
    begin
        s_d = s_q;
        // only the second stage is read by logic
        s_d.rx_meta = rx_pin;
        s_d.rx_sync = s_q.rx_meta;

        // one wait cycle per request, answer in the next
        bus_go = (avl_req.read || avl_req.write) && s_q.waitreq;
        s_d.waitreq = !bus_go;
        st_rd = bus_go && avl_req.read && avl_req.address == SSF_OFS_STATUS;
        dl_rd = bus_go && avl_req.read && avl_req.address == SSF_OFS_DATA_LOW;
        dl_wr = bus_go && avl_req.write && avl_req.address == SSF_OFS_DATA_LOW;
        dh_wr = bus_go && avl_req.write && avl_req.address == SSF_OFS_DATA_HIGH;
        ctl_wr = bus_go && avl_req.write && avl_req.address == SSF_OFS_CTRL;

        // read mux; unmapped addresses read zero
        s_d.rdata = '0;
        if (avl_req.address == SSF_OFS_CTRL)
            s_d.rdata[4:0] = s_q.ctrl;
        else if (avl_req.address == SSF_OFS_STATUS)
            s_d.rdata[7:0] = s_q.flags;
        else if (avl_req.address == SSF_OFS_DATA_HIGH)
        begin
            s_d.rdata[SSF_DH_R8] = s_q.rx_word[8];
            s_d.rdata[SSF_DH_T8] = s_q.tx_word[8];
        end
        else if (avl_req.address == SSF_OFS_DATA_LOW)
            s_d.rdata[7:0] = s_q.rx_word[7:0];

        if (ctl_wr)
            s_d.ctrl = avl_req.writedata[4:0];
        if (dh_wr)
            s_d.tx_word[8] = avl_req.writedata[SSF_DH_T8];
        // a status write matches none of the strobes above

        // snapshot of the flags seen set by software
        if (st_rd)
            s_d.armed = s_q.flags;

        // transmit side clears
        tc_sw_clear = 1'b0;
        if (dl_wr)
        begin
            s_d.tx_word[7:0] = avl_req.writedata[7:0];
            if (s_q.armed.tx_buffer_empty_flag)
                s_d.flags.tx_buffer_empty_flag = 1'b0;
            if (s_q.armed.tc)
            begin
                s_d.flags.tc = 1'b0;
                tc_sw_clear = 1'b1;
            end
            s_d.armed.tx_buffer_empty_flag = 1'b0;
            s_d.armed.tc = 1'b0;
        end

        // receive side clears
        if (dl_rd)
        begin
            if (s_q.armed.rx_full_flag)
                s_d.flags.rx_full_flag = 1'b0;
            if (s_q.armed.idle)
            begin
                s_d.flags.idle = 1'b0;
                s_d.idle_allow = 1'b0;
            end
            // overrun missed by the snapshot needs one more status read, then a data read
            if (s_q.armed.ovr)
                s_d.flags.ovr = 1'b0;
            if (s_q.armed.nf)
                s_d.flags.nf = 1'b0;
            if (s_q.armed.fe)
                s_d.flags.fe = 1'b0;
            if (s_q.armed.pf)
                s_d.flags.pf = 1'b0;
            s_d.armed.rx_full_flag = 1'b0;
            s_d.armed.idle = 1'b0;
            s_d.armed.ovr = 1'b0;
            s_d.armed.nf = 1'b0;
            s_d.armed.fe = 1'b0;
            s_d.armed.pf = 1'b0;
        end

        // hardware sets win over software clears, except for tc
        if (tx_evt.load)
            s_d.flags.tx_buffer_empty_flag = 1'b1;
        if (tx_evt.busy || tx_evt.queue)
            s_d.busy_seen = 1'b1;
        if (tx_evt.queue)
            s_d.flags.tc = 1'b0;
        else if (tx_evt.busy)
            s_d.flags.tc = 1'b0;
        else if (s_q.busy_seen && s_d.flags.tx_buffer_empty_flag && !tc_sw_clear)
        begin
            s_d.flags.tc = 1'b1;
            s_d.busy_seen = 1'b0;
        end
        // a clear in the same cycle keeps tc low

        // parity over the data bits of the chosen format
        par_bad = s_q.ctrl[SSF_CTL_PAR_EN]
            && ((^rx_evt.data[7:0]) ^ (s_q.ctrl[SSF_CTL_NINE] & rx_evt.data[8])
            ^ rx_evt.parity_bit ^ s_q.ctrl[SSF_CTL_PAR_ODD]);

        accept = rx_evt.valid && !s_q.rx_hold;
        if (accept)
        begin
            if (s_q.flags.rx_full_flag)
                s_d.flags.ovr = 1'b1;
            else
            begin
                s_d.rx_word = rx_evt.data;
                if (!s_q.ctrl[SSF_CTL_NINE])
                    s_d.rx_word[8] = 1'b0;
                s_d.flags.rx_full_flag = 1'b1;
                s_d.idle_allow = 1'b1;
                if (rx_evt.noise)
                    s_d.flags.nf = 1'b1;
                if (rx_evt.stop_low)
                    s_d.flags.fe = 1'b1;
                if (par_bad)
                    s_d.flags.pf = 1'b1;
            end
        end

        if (idle_pulse && s_q.idle_allow && !s_q.ctrl[SSF_CTL_WAKEUP])
            s_d.flags.idle = 1'b1;

        // reception stays blocked until the fe and ovr flags are cleared
        s_d.rx_hold = s_d.flags.fe || s_d.flags.ovr;
        s_d.irq = s_d.ctrl[SSF_CTL_RIE] && (s_d.flags.rx_full_flag || s_d.flags.ovr);
        s_d.tx_pin = s_d.flags.tc ? 1'b1 : tx_evt.line_bit;
        // registered so the engine sees a clean level, not a gate output
        s_d.tx_pending = !s_d.flags.tx_buffer_empty_flag;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.flags <= SSF_FLAGS_RST;
            s_q.ctrl <= SSF_CTRL_RST;
            s_q.idle_allow <= 1'b1;
            s_q.waitreq <= 1'b1;
            s_q.tx_pin <= 1'b1;
            s_q.rx_meta <= 1'b1;
            s_q.rx_sync <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign avl_waitrequest = s_q.waitreq;
    assign avl_readdata = s_q.rdata;
    assign tx_word = s_q.tx_word;
    assign tx_word_pending = s_q.tx_pending;
    assign tx_pin = s_q.tx_pin;
    assign rx_hold = s_q.rx_hold;
    assign frame_nine_bits = s_q.ctrl[SSF_CTL_NINE];
    assign parity_enable = s_q.ctrl[SSF_CTL_PAR_EN];
    assign parity_kind = s_q.ctrl[SSF_CTL_PAR_ODD];
    assign rx_wakeup_standby = s_q.ctrl[SSF_CTL_WAKEUP];
    assign rx_irq_req = s_q.irq;

    a_status_write_ignored: assert property (@(posedge sys_clk) disable iff (rst)
        (avl_req.write && avl_waitrequest && avl_req.address == SSF_OFS_STATUS
        && !tx_evt.load && !tx_evt.busy && !tx_evt.queue && !rx_evt.valid && !idle_pulse)
        |=> $stable(s_q.flags))
        else $error("status write changed a flag");

    a_tx_buffer_empty_flag_on_load: assert property (@(posedge sys_clk) disable iff (rst)
        tx_evt.load |=> s_q.flags.tx_buffer_empty_flag && !tx_word_pending)
        else $error("buffer empty not set after load");

    a_tc_clear_wins: assert property (@(posedge sys_clk) disable iff (rst)
        (tx_evt.queue || tx_evt.busy) |=> !s_q.flags.tc)
        else $error("done flag high while sending");

    a_tc_idle_pin: assert property (@(posedge sys_clk) disable iff (rst)
        s_q.flags.tc |-> tx_pin)
        else $error("transmit pin low while done");

    a_rx_full_flag_load_word: assert property (@(posedge sys_clk) disable iff (rst)
        (rx_evt.valid && !rx_hold && !s_q.flags.rx_full_flag)
        |=> s_q.flags.rx_full_flag && s_q.rx_word[7:0] == $past(rx_evt.data[7:0]))
        else $error("receive word not taken");

    a_overrun_keep_old: assert property (@(posedge sys_clk) disable iff (rst)
        (rx_evt.valid && !rx_hold && s_q.flags.rx_full_flag)
        |=> s_q.flags.ovr && $stable(s_q.rx_word) && rx_hold)
        else $error("overrun lost old word");

    a_idle_no_wakeup: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_q.flags.idle) |-> !$past(s_q.ctrl[SSF_CTL_WAKEUP]) && $past(idle_pulse))
        else $error("idle set during standby");

    a_error_with_full: assert property (@(posedge sys_clk) disable iff (rst)
        ($rose(s_q.flags.nf) || $rose(s_q.flags.fe) || $rose(s_q.flags.pf))
        |-> $rose(s_q.flags.rx_full_flag))
        else $error("error flag set without receive full");

    a_irq_gated: assert property (@(posedge sys_clk) disable iff (rst)
        rx_irq_req |-> s_q.ctrl[SSF_CTL_RIE] && (s_q.flags.rx_full_flag || s_q.flags.ovr))
        else $error("receive interrupt without cause");

    a_clear_needs_read: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(s_q.flags.rx_full_flag) |-> $past(s_q.armed.rx_full_flag))
        else $error("receive full cleared without status read");

    a_tc_queue_clear: assert property (@(posedge sys_clk) disable iff (rst)
        tx_evt.queue |=> !s_q.flags.tc)
        else $error("done flag high after queueing");

    a_fe_blocks_rx: assert property (@(posedge sys_clk) disable iff (rst)
        s_q.flags.fe |-> rx_hold)
        else $error("reception open with stop bit error");

    a_no_err_overrun: assert property (@(posedge sys_clk) disable iff (rst)
        (rx_evt.valid && !rx_hold && s_q.flags.rx_full_flag)
        |=> !$rose(s_q.flags.nf) && !$rose(s_q.flags.fe) && !$rose(s_q.flags.pf))
        else $error("error flag set on overrun frame");

    a_idle_needs_frame: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_q.flags.idle) |-> $past(s_q.idle_allow))
        else $error("idle set again without a frame");

    a_pending_mirror: assert property (@(posedge sys_clk) disable iff (rst)
        tx_word_pending == !s_q.flags.tx_buffer_empty_flag)
        else $error("pending level disagrees with buffer empty");

    a_irq_off: assert property (@(posedge sys_clk) disable iff (rst)
        !s_q.ctrl[SSF_CTL_RIE] |-> !rx_irq_req)
        else $error("receive interrupt while disabled");

    a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
        ((avl_req.read || avl_req.write) && avl_waitrequest) |=> !avl_waitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// file: tb/ssf_engine_model.sv
// model of the shift engines and the remote line facing the status flag logic
`timescale 1ns/1ns
`default_nettype none
module ssf_engine_model
    import ssf_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // engine events
    output var ssf_pkg::ssf_tx_evt_t tx_evt,
    output var ssf_pkg::ssf_rx_evt_t rx_evt,
    // line timing
    output var logic rx_pin,
    output var logic rx_bit_tick
);
    initial
    begin
        tx_evt = 4'h1;
        rx_evt = '0;
        rx_pin = 1'b1;
        rx_bit_tick = 1'b0;
    end

    // fields scrambled after the pulse so stale data never looks valid
    task automatic frame(input logic [8:0] d, input logic p, n, s);
        rx_evt <= '{1'b1, d, p, n, s};
        @(posedge sys_clk);
        rx_evt <= '{1'b0, ~d, ~p, ~n, ~s};
        @(posedge sys_clk);
    endtask

    // queue a frame and start sending it with the line low
    task automatic tx_start;
        tx_evt <= '{1'b0, 1'b1, 1'b1, 1'b0};
        @(posedge sys_clk);
        tx_evt.queue <= 1'b0;
    endtask

    // shifter takes the word, then the engine goes quiet
    task automatic tx_end;
        tx_evt.load <= 1'b1;
        @(posedge sys_clk);
        tx_evt <= 4'h1;
        @(posedge sys_clk);
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            repeat (3) @(posedge sys_clk);
            rx_bit_tick <= 1'b1;
            @(posedge sys_clk);
            rx_bit_tick <= 1'b0;
        end
    endtask

    // one low bit restarts the count, then n high bit times
    task automatic idle(input int n);
        rx_pin <= 1'b0;
        tick(1);
        rx_pin <= 1'b1;
        tick(n);
        repeat (4) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/ssf_status_flags_tb.sv
// self-checking bench for the serial status flag logic
`timescale 1ns/1ns
`default_nettype none
module ssf_status_flags_tb;
    import ssf_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ssf_avl_req_t avl_req = '0;
    ssf_tx_evt_t tx_evt;
    ssf_rx_evt_t rx_evt;
    logic avl_waitrequest, tx_word_pending, tx_pin, rx_pin, rx_bit_tick, rx_hold;
    logic frame_nine_bits, parity_enable, parity_kind, rx_wakeup_standby, rx_irq_req;
    logic [31:0] avl_readdata, rdv;
    logic [8:0] tx_word, d;
    logic [7:0] w;
    logic [4:0] c;
    logic p, n;
    int n_mismatch = 0;
    int num_checks = 0;

    ssf_status_flags i_ssf_status_flags (.sys_clk, .rst, .avl_req, .avl_waitrequest,
        .avl_readdata, .tx_evt, .tx_word, .tx_word_pending, .tx_pin, .rx_evt, .rx_pin,
        .rx_bit_tick, .rx_hold, .frame_nine_bits, .parity_enable, .parity_kind,
        .rx_wakeup_standby, .rx_irq_req);
    ssf_engine_model i_ssf_engine_model (.sys_clk, .tx_evt, .rx_evt, .rx_pin, .rx_bit_tick);

    always #10 sys_clk = ~sys_clk;

    task automatic wrap_up;
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one bus transfer, held until waitrequest is seen low
    task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int k = 0;
        avl_req <= '{~wr, wr, a, wd};
        @(posedge sys_clk);
        while (avl_waitrequest !== 1'b0)
        begin
            k++;
            if (k > 50)
            begin
                n_mismatch++;
                wrap_up();
            end
            @(posedge sys_clk);
        end
        rdv = avl_readdata;
        avl_req <= '0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask

    // receive flags expected for a frame taken while the data register was empty
    function automatic logic [31:0] rx_flags(logic [8:0] dv, logic pv, nv, logic [4:0] cv);
        logic pf;
        pf = cv[SSF_CTL_PAR_EN] & ((^(cv[SSF_CTL_NINE] ? dv : {1'b0, dv[7:0]}) ^ pv)
            != cv[SSF_CTL_PAR_ODD]);
        return 32'h20 | {29'h0, nv, 1'b0, pf};
    endfunction

    initial
    begin
        void'($urandom(32'hB8F309CB));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(SSF_OFS_STATUS, 32'hC0);
        rd(SSF_OFS_CTRL, 32'h0);
        rd(5'h10, 32'h0);
        acc(1'b1, SSF_OFS_STATUS, 32'hFF);
        rd(SSF_OFS_STATUS, 32'hC0);
        for (int i = 0; i < 8; i++)
        begin
            c = 5'($urandom) & 5'h17;
            {d, p, n} = 11'($urandom);
            acc(1'b1, SSF_OFS_CTRL, {27'h0, c});
            chk(32'({rx_wakeup_standby, parity_kind, parity_enable, frame_nine_bits}),
                32'(c[3:0]));
            i_ssf_engine_model.frame(d, p, n, 1'b0);
            rd(SSF_OFS_DATA_LOW, 32'(d[7:0]));
            rd(SSF_OFS_STATUS, 32'hC0 | rx_flags(d, p, n, c));
            chk(32'(rx_irq_req), 32'(c[SSF_CTL_RIE]));
            rd(SSF_OFS_CTRL, 32'(c));
            acc(1'b0, SSF_OFS_DATA_HIGH, 32'h0);
            chk(rdv & 32'h80, c[SSF_CTL_NINE] ? 32'({d[8], 7'h0}) : 32'h0);
            rd(SSF_OFS_DATA_LOW, 32'(d[7:0]));
            rd(SSF_OFS_STATUS, 32'hC0);
            chk(32'(rx_irq_req), 32'h0);
        end
        acc(1'b1, SSF_OFS_CTRL, 32'h0);
        i_ssf_engine_model.frame(9'h0A5, 1'b0, 1'b0, 1'b1);
        i_ssf_engine_model.frame(9'h05A, 1'b0, 1'b0, 1'b0);
        rd(SSF_OFS_STATUS, 32'hE2);
        chk(32'(rx_hold), 32'h1);
        rd(SSF_OFS_DATA_LOW, 32'hA5);
        rd(SSF_OFS_STATUS, 32'hC0);
        chk(32'(rx_hold), 32'h0);
        acc(1'b1, SSF_OFS_CTRL, 32'h10);
        i_ssf_engine_model.frame(9'h011, 1'b0, 1'b0, 1'b0);
        rd(SSF_OFS_STATUS, 32'hE0);
        i_ssf_engine_model.frame(9'h022, 1'b0, 1'b1, 1'b0);
        rd(SSF_OFS_DATA_LOW, 32'h11);
        rd(SSF_OFS_STATUS, 32'hC8);
        chk(32'({rx_hold, rx_irq_req}), 32'h3);
        rd(SSF_OFS_DATA_LOW, 32'h11);
        rd(SSF_OFS_STATUS, 32'hC0);
        chk(32'({rx_hold, rx_irq_req}), 32'h0);
        acc(1'b1, SSF_OFS_CTRL, 32'h0);
        i_ssf_engine_model.idle(9);
        rd(SSF_OFS_STATUS, 32'hC0);
        i_ssf_engine_model.idle(10);
        rd(SSF_OFS_STATUS, 32'hD0);
        rd(SSF_OFS_DATA_LOW, 32'h11);
        i_ssf_engine_model.idle(10);
        rd(SSF_OFS_STATUS, 32'hC0);
        for (int m = 0; m < 2; m++)
        begin
            c = m ? 5'h08 : 5'h01;
            acc(1'b1, SSF_OFS_CTRL, {27'h0, c});
            i_ssf_engine_model.frame(9'h033, 1'b0, 1'b0, 1'b0);
            rd(SSF_OFS_STATUS, 32'hE0);
            rd(SSF_OFS_DATA_LOW, 32'h33);
            i_ssf_engine_model.idle(10);
            rd(SSF_OFS_STATUS, 32'hC0);
            i_ssf_engine_model.idle(11);
            rd(SSF_OFS_STATUS, m ? 32'hC0 : 32'hD0);
            acc(1'b0, SSF_OFS_DATA_LOW, 32'h0);
        end
        w = 8'($urandom);
        rd(SSF_OFS_STATUS, 32'hC0);
        acc(1'b1, SSF_OFS_DATA_HIGH, 32'h40);
        acc(1'b1, SSF_OFS_DATA_LOW, {24'h0, w});
        chk(32'({tx_word_pending, tx_word}), 32'({2'h3, w}));
        rd(SSF_OFS_STATUS, 32'h0);
        i_ssf_engine_model.tx_start();
        repeat (3) @(posedge sys_clk);
        chk(32'(tx_pin), 32'h0);
        i_ssf_engine_model.tx_end();
        rd(SSF_OFS_STATUS, 32'hC0);
        chk(32'({tx_pin, tx_word_pending}), 32'h2);
        i_ssf_engine_model.tx_start();
        rd(SSF_OFS_STATUS, 32'h80);
        i_ssf_engine_model.tx_end();
        rd(SSF_OFS_STATUS, 32'hC0);
        wrap_up();
    end
endmodule
`default_nettype wire
